/* design/eiep_consts.svh */
/*
 Constants of the extended interrupt enable and priority block: register
 indices, field positions, reset values and the source count.
 Assumes inclusion by the top module and the bench only.
*/
// Functional notes
// RULE1: Second extended enable register resets to all zeros, masking its sources.
// RULE2: First extended priority register resets to all zeros, all low priority.
// RULE3: Enable bit 7 passes or blocks the oscillator-valid interrupt.
// RULE4: Enable bit 6 passes or blocks the second serial port interrupt.
// RULE5: Enable bit 5 passes or blocks external pin seven interrupt.
// RULE6: Enable bit 4 passes or blocks external pin six interrupt.
// RULE7: Enable bit 3 passes or blocks second converter end-of-conversion interrupt.
// RULE8: Enable bit 0 passes or blocks the timer three overflow interrupt.
// RULE9: Priority bits 7..4 set comparator rise and fall interrupt levels.
// RULE10: Priority bit 3 sets the counter array interrupt level.
// RULE11: Priority bit 2 sets the converter window-compare interrupt level.
// RULE12: Priority bit 1 sets the two-wire bus interrupt level.
// RULE13: Priority bit 0 sets the serial peripheral interrupt level.
// RULE14: High level preempts low level service; fixed order breaks ties.
`ifndef EIEP_CONSTS_SVH
`define EIEP_CONSTS_SVH

`define EIEP_EN2_IDX        8'he7
`define EIEP_PRIO1_IDX      8'hf6
`define EIEP_EN2_RST        8'h00
`define EIEP_PRIO1_RST      8'h00

`define EIEP_OSC_VALID_BIT  7
`define EIEP_UART2_BIT      6
`define EIEP_PIN7_BIT       5
`define EIEP_PIN6_BIT       4
`define EIEP_CONV_B_BIT     3
`define EIEP_TIMER4_BIT     2
`define EIEP_CONV_A_BIT     1
`define EIEP_TIMER3_BIT     0

`define EIEP_CMP_B_RISE_BIT 7
`define EIEP_CMP_B_FALL_BIT 6
`define EIEP_CMP_A_RISE_BIT 5
`define EIEP_CMP_A_FALL_BIT 4
`define EIEP_PCA_BIT        3
`define EIEP_WINDOW_BIT     2
`define EIEP_TWO_WIRE_BIT   1
`define EIEP_SPI_BIT        0

`define EIEP_NUM_SRC        16

`endif

/* design/eiep_pkg.sv */
/*
 Types of the extended interrupt enable and priority block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eiep_pkg;

	typedef struct packed {
		logic [7:0] maskedReq;
		logic [7:0] maskedLvl;
		logic [7:0] leveledReq;
		logic [7:0] leveledEn;
	} eiep_src_s;

	typedef struct packed {
		logic       req;
		logic       high;
		logic [3:0] id;
	} eiep_offer_s;

	typedef struct packed {
		logic [7:0]  enable;
		logic [7:0]  prio;
		logic        waitReq;
		logic [31:0] rdata;
		logic [7:0]  gated;
		eiep_offer_s offer;
		logic        svcLow;
		logic        svcHigh;
	} eiep_state_s;

endpackage

/* design/eiep_top.sv */
/*
 Extended interrupt enable and priority block: two registers on an
 Avalon-MM slave, request gating and a two-level arbiter offering one
 interrupt at a time to the processor's interrupt sequencer.
 Assumes request flags and sequencer strobes synchronous to clk.
*/
`timescale 1ns/1ps
`include "eiep_consts.svh"

module eiep_top (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [9:0]           address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [3:0]           byteenable,
	input  wire logic [31:0]          writedata,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	input  wire eiep_pkg::eiep_src_s  src,
	input  wire logic                 seqAck,
	input  wire logic                 seqReturn,
	output logic      [7:0]           gatedReq,
	output eiep_pkg::eiep_offer_s     offer
);
	import eiep_pkg::*;

	eiep_state_s st;
	eiep_state_s next_st;

	logic [15:0] pend;
	logic [15:0] lvl;
	logic [15:0] pendHigh;
	logic [15:0] pendLow;
	logic        hitEn;
	logic        hitPrio;
	logic        busReq;

	// Lowest index wins; used for both levels
	function automatic logic [3:0] firstIdx(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// Gated sources sit at 8..15, leveled sources at 0..7
	always_comb begin
		pend     = {src.maskedReq & st.enable, src.leveledReq & src.leveledEn}; // [RULE3] [RULE8]
		lvl      = {src.maskedLvl, st.prio}; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]
		pendHigh = pend & lvl;
		pendLow  = pend & ~lvl;
		busReq   = read | write;
		hitEn    = address == {`EIEP_EN2_IDX, 2'b00};
		hitPrio  = address == {`EIEP_PRIO1_IDX, 2'b00};
	end

	always_comb begin
		next_st = st;
		// One wait cycle, then a single ready cycle per request
		next_st.waitReq = !(busReq && st.waitReq);
		next_st.rdata   = 32'h0;
		if (read && st.waitReq) begin
			if (hitEn) begin
				next_st.rdata = {24'h0, st.enable};
			end else if (hitPrio) begin
				next_st.rdata = {24'h0, st.prio};
			end
		end
		// Unmapped writes are dropped, unmapped reads give zero
		if (write && !st.waitReq && byteenable[0]) begin
			if (hitEn) begin
				next_st.enable = writedata[7:0];
			end
			if (hitPrio) begin
				next_st.prio = writedata[7:0];
			end
		end

		next_st.gated = src.maskedReq & st.enable; // [RULE4] [RULE5] [RULE6] [RULE7]

		// Return from service closes the deepest open level first
		if (seqReturn) begin
			if (st.svcHigh) begin
				next_st.svcHigh = 1'b0;
			end else begin
				next_st.svcLow = 1'b0;
			end
		end

		next_st.offer = '0;
		if (seqAck && st.offer.req) begin
			// Gap cycle after a take avoids offering the same source twice
			if (st.offer.high) begin
				next_st.svcHigh = 1'b1;
			end else begin
				next_st.svcLow = 1'b1;
			end
		end else if (|pendHigh && !st.svcHigh) begin
			next_st.offer.req  = 1'b1; // [RULE14]
			next_st.offer.high = 1'b1;
			next_st.offer.id   = firstIdx(pendHigh);
		end else if (|pendLow && !st.svcHigh && !st.svcLow) begin
			next_st.offer.req  = 1'b1;
			next_st.offer.high = 1'b0;
			next_st.offer.id   = firstIdx(pendLow); // [RULE14]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st         <= '0;
			st.enable  <= `EIEP_EN2_RST; // [RULE1]
			st.prio    <= `EIEP_PRIO1_RST; // [RULE2]
			st.waitReq <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign readdata    = st.rdata;
	assign waitrequest = st.waitReq;
	assign gatedReq    = st.gated;
	assign offer       = st.offer;

	a_enable_reset_zero: assert property ( // [RULE1]
		@(posedge clk) !rstn |-> st.enable == 8'h00
	) else $error("Enable register not cleared by reset");

	a_prio_reset_zero: assert property ( // [RULE2]
		@(posedge clk) !rstn |-> st.prio == 8'h00
	) else $error("Priority register not cleared by reset");

	a_osc_valid_gate: assert property ( // [RULE3]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_OSC_VALID_BIT] && !st.enable[`EIEP_OSC_VALID_BIT])
		|=> !gatedReq[`EIEP_OSC_VALID_BIT]
	) else $error("Masked oscillator-valid request passed");

	a_uart_two_gate: assert property ( // [RULE4]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_UART2_BIT] && st.enable[`EIEP_UART2_BIT])
		|=> gatedReq[`EIEP_UART2_BIT]
	) else $error("Enabled second serial port request lost");

	a_pin_seven_gate: assert property ( // [RULE5]
		@(posedge clk) disable iff (!rstn)
		gatedReq[`EIEP_PIN7_BIT]
		|-> $past(src.maskedReq[`EIEP_PIN7_BIT] && st.enable[`EIEP_PIN7_BIT])
	) else $error("Pin seven request passed without cause");

	a_pin_six_gate: assert property ( // [RULE6]
		@(posedge clk) disable iff (!rstn)
		gatedReq[`EIEP_PIN6_BIT]
		|-> $past(src.maskedReq[`EIEP_PIN6_BIT] && st.enable[`EIEP_PIN6_BIT])
	) else $error("Pin six request passed without cause");

	a_conv_b_gate: assert property ( // [RULE7]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_CONV_B_BIT] && st.enable[`EIEP_CONV_B_BIT])
		|=> gatedReq[`EIEP_CONV_B_BIT]
	) else $error("Enabled conversion request lost");

	a_timer_three_gate: assert property ( // [RULE8]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_TIMER3_BIT] && !st.enable[`EIEP_TIMER3_BIT])
		|=> !gatedReq[`EIEP_TIMER3_BIT]
	) else $error("Masked timer three request passed");

	a_cmp_level_high: assert property ( // [RULE9]
		@(posedge clk) disable iff (!rstn)
		(offer.req && offer.id >= 4'h4 && offer.id <= 4'h7)
		|-> offer.high == |(($past(st.prio) >> offer.id[2:0]) & 8'h01)
	) else $error("Comparator interrupt offered at wrong level");

	a_pca_level: assert property ( // [RULE10]
		@(posedge clk) disable iff (!rstn)
		(offer.req && offer.id == 4'h3) |-> offer.high == $past(st.prio[`EIEP_PCA_BIT])
	) else $error("Counter array interrupt offered at wrong level");

	a_window_level: assert property ( // [RULE11]
		@(posedge clk) disable iff (!rstn)
		(offer.req && offer.id == 4'h2) |-> offer.high == $past(st.prio[`EIEP_WINDOW_BIT])
	) else $error("Window interrupt offered at wrong level");

	a_two_wire_level: assert property ( // [RULE12]
		@(posedge clk) disable iff (!rstn)
		(offer.req && offer.id == 4'h1) |-> offer.high == $past(st.prio[`EIEP_TWO_WIRE_BIT])
	) else $error("Two-wire bus interrupt offered at wrong level");

	a_spi_level: assert property ( // [RULE13]
		@(posedge clk) disable iff (!rstn)
		(offer.req && offer.id == 4'h0) |-> offer.high == $past(st.prio[`EIEP_SPI_BIT])
	) else $error("Serial peripheral interrupt offered at wrong level");

	a_high_preempts: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		(|pendHigh && st.svcLow && !st.svcHigh && !seqAck && !seqReturn)
		|=> offer.req && offer.high
	) else $error("High level request did not preempt low service");

	a_low_blocked: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		st.svcHigh |=> !(offer.req && !offer.high)
	) else $error("Low level offered during high service");

	a_fixed_order: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		(pendHigh[0] && !st.svcHigh && !(seqAck && offer.req))
		|=> offer.req && offer.id == 4'h0
	) else $error("Fixed order not kept among high requests");

	a_bus_answer: assert property (
		@(posedge clk) disable iff (!rstn)
		((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest
	) else $error("Bus answer not one cycle after request");

	a_osc_valid_pass: assert property ( // [RULE3]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_OSC_VALID_BIT] && st.enable[`EIEP_OSC_VALID_BIT])
		|=> gatedReq[`EIEP_OSC_VALID_BIT]
	) else $error("Enabled oscillator-valid request lost");

	a_uart_two_block: assert property ( // [RULE4]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_UART2_BIT] && !st.enable[`EIEP_UART2_BIT])
		|=> !gatedReq[`EIEP_UART2_BIT]
	) else $error("Masked second serial port request passed");

	a_pin_seven_block: assert property ( // [RULE5]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_PIN7_BIT] && !st.enable[`EIEP_PIN7_BIT])
		|=> !gatedReq[`EIEP_PIN7_BIT]
	) else $error("Masked pin seven request passed");

	a_pin_six_block: assert property ( // [RULE6]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_PIN6_BIT] && !st.enable[`EIEP_PIN6_BIT])
		|=> !gatedReq[`EIEP_PIN6_BIT]
	) else $error("Masked pin six request passed");

	a_conv_b_block: assert property ( // [RULE7]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_CONV_B_BIT] && !st.enable[`EIEP_CONV_B_BIT])
		|=> !gatedReq[`EIEP_CONV_B_BIT]
	) else $error("Masked conversion request passed");

	a_timer_three_pass: assert property ( // [RULE8]
		@(posedge clk) disable iff (!rstn)
		(src.maskedReq[`EIEP_TIMER3_BIT] && st.enable[`EIEP_TIMER3_BIT])
		|=> gatedReq[`EIEP_TIMER3_BIT]
	) else $error("Enabled timer three request lost");

	a_enable_write: assert property (
		@(posedge clk) disable iff (!rstn)
		(write && !waitrequest && byteenable[0] && hitEn) |=> st.enable == $past(writedata[7:0])
	) else $error("Enable register write lost");

	a_prio_write: assert property (
		@(posedge clk) disable iff (!rstn)
		(write && !waitrequest && byteenable[0] && hitPrio) |=> st.prio == $past(writedata[7:0])
	) else $error("Priority register write lost");

	a_write_ignored: assert property (
		@(posedge clk) disable iff (!rstn)
		(write && !waitrequest && !byteenable[0]) |=> $stable(st.enable) && $stable(st.prio)
	) else $error("Write without low byte lane changed a register");

	a_read_enable: assert property (
		@(posedge clk) disable iff (!rstn)
		(read && waitrequest && hitEn) |=> readdata == {24'h000000, $past(st.enable)}
	) else $error("Enable register read wrong");

	a_read_prio: assert property (
		@(posedge clk) disable iff (!rstn)
		(read && waitrequest && hitPrio) |=> readdata == {24'h000000, $past(st.prio)}
	) else $error("Priority register read wrong");

	a_take_gap: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		(seqAck && offer.req) |=> !offer.req
	) else $error("Offer not withdrawn after a take");

	a_high_service_quiet: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		st.svcHigh |=> !offer.req
	) else $error("Interrupt offered during high service");

	a_return_high_first: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		(seqReturn && st.svcHigh) |=> !st.svcHigh && st.svcLow == $past(st.svcLow)
	) else $error("Return did not close high service first");

	a_offer_pending: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rstn)
		offer.req |-> |($past(pend) & (16'h0001 << offer.id))
	) else $error("Offered interrupt was not pending");

endmodule // eiep_top

/* verification/eiep_partner.sv */
/*
 Model of the processor interrupt sequencer: takes offers and returns.
 Assumes offer is registered on the rising edge of clk.
*/
`timescale 1ns/1ps
module eiep_partner (
	input  wire logic                  clk,
	input  wire eiep_pkg::eiep_offer_s offer,
	output logic                       seqAck,
	output logic                       seqReturn
);
	import eiep_pkg::*;
	initial begin
		seqAck = 1'b0;
		seqReturn = 1'b0;
	end
	// Lag models a slow sequencer; it never acks an absent offer
	task automatic ackOne(input int lag);
		repeat (lag) @(posedge clk);
		while (offer.req !== 1'b1) @(posedge clk);
		seqAck <= 1'b1;
		@(posedge clk);
		seqAck <= 1'b0;
	endtask
	task automatic retOne();
		seqReturn <= 1'b1;
		@(posedge clk);
		seqReturn <= 1'b0;
	endtask
endmodule // eiep_partner

/* verification/eiep_tb_top.sv */
/*
 Self-checking bench: Avalon register access, gating and arbitration.
 Assumes the partner sequencer model and the design's consts header.
*/
`timescale 1ns/1ps
`include "eiep_consts.svh"
module eiep_tb_top;
	import eiep_pkg::*;
	localparam logic [9:0] ADDR_EN = {`EIEP_EN2_IDX, 2'b00};
	localparam logic [9:0] ADDR_PR = {`EIEP_PRIO1_IDX, 2'b00};
	logic        clk, rstn, read, write, waitrequest, seqAck, seqReturn;
	logic [9:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata;
	logic [7:0]  gatedReq, en, pr;
	eiep_src_s   src;
	eiep_offer_s offer;
	logic [31:0] rdQ[$];
	logic [13:0] outQ[$];
	int          error_cnt = 0;
	int          n_compared = 0;

	eiep_top DUT (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .src(src), .seqAck(seqAck), .seqReturn(seqReturn),
		.gatedReq(gatedReq), .offer(offer));
	eiep_partner seq (.clk(clk), .offer(offer), .seqAck(seqAck), .seqReturn(seqReturn));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] be, input logic [31:0] exp);
		@(posedge clk);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		if (wr) write <= 1'b1;
		else begin
			read <= 1'b1;
			rdQ.push_back(exp);
		end
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// Noted mid-cycle, compared by the monitor at the next rising edge
	task automatic expOut(input logic [13:0] e);
		@(negedge clk);
		outQ.push_back(e);
		@(posedge clk);
	endtask

	// No service open: lowest id of the highest pending level wins
	function automatic logic [13:0] model(input eiep_src_s s, input logic [7:0] e,
		input logic [7:0] p);
		logic [15:0] pend, hi;
		logic [5:0]  o;
		pend = {s.maskedReq & e, s.leveledReq & s.leveledEn};
		hi = pend & {s.maskedLvl, p};
		o = 6'h0;
		for (int i = 15; i >= 0; i--) if (pend[i]) o = {2'b10, i[3:0]};
		for (int i = 15; i >= 0; i--) if (hi[i]) o = {2'b11, i[3:0]};
		return {s.maskedReq & e, o};
	endfunction

	always @(posedge clk) begin : monitor
		logic [13:0] e;
		if (read === 1'b1 && waitrequest === 1'b0 && rdQ.size() > 0)
			check("readdata", readdata, rdQ.pop_front());
		if (outQ.size() > 0) begin
			e = outQ.pop_front();
			check("gatedReq", {24'h0, gatedReq}, {24'h0, e[13:6]});
			check("offer", e[5] ? {26'h0, offer} : {31'h0, offer.req}, {26'h0, e[5:0]});
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h8426510a));
		rstn = 1'b1;
		{read, write, address, byteenable, writedata} = '0;
		src = '0;
		// Dropped after an edge so the reset edge is never lost at time zero
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		expOut(14'h0);
		bus(1'b0, ADDR_EN, 8'h0, 4'h1, {24'h0, `EIEP_EN2_RST});
		bus(1'b0, ADDR_PR, 8'h0, 4'h1, {24'h0, `EIEP_PRIO1_RST});
		$display("Test reset values done");
		en = $urandom;
		pr = $urandom;
		bus(1'b1, ADDR_EN, en, 4'h1, 0);
		bus(1'b1, ADDR_PR, pr, 4'h1, 0);
		bus(1'b1, ADDR_EN, ~en, 4'h0, 0);
		bus(1'b1, 10'h000, 8'hff, 4'h1, 0);
		bus(1'b0, 10'h000, 8'h0, 4'h1, 0);
		bus(1'b0, ADDR_EN, 8'h0, 4'h1, {24'h0, en});
		bus(1'b0, ADDR_PR, 8'h0, 4'h1, {24'h0, pr});
		$display("Test register access done");
		repeat (16) begin
			en = $urandom;
			pr = $urandom;
			bus(1'b1, ADDR_EN, en, 4'h1, 0);
			bus(1'b1, ADDR_PR, pr, 4'h1, 0);
			@(posedge clk);
			src <= eiep_src_s'($urandom);
			repeat (2) @(posedge clk);
			expOut(model(src, en, pr));
		end
		$display("Test gating and levels done");
		bus(1'b1, ADDR_EN, 8'h00, 4'h1, 0);
		bus(1'b1, ADDR_PR, 8'h01, 4'h1, 0);
		@(posedge clk);
		src <= eiep_src_s'(32'h000002ff);
		repeat (2) @(posedge clk);
		expOut({8'h0, 6'h21});
		seq.ackOne($urandom_range(3));
		expOut(14'h0);
		src <= eiep_src_s'(32'h000003ff);
		repeat (2) @(posedge clk);
		expOut({8'h0, 6'h30});
		seq.ackOne(1);
		expOut(14'h0);
		seq.retOne();
		@(posedge clk);
		expOut({8'h0, 6'h30});
		src <= eiep_src_s'(32'h000002ff);
		seq.retOne();
		@(posedge clk);
		expOut({8'h0, 6'h21});
		$display("Test preemption done");
		end_of_test();
	end
endmodule // eiep_tb_top
